// ---- verilog/mitid_pkg.sv ----
// Shared constants and types for the inline macroblock parameter decoder
package mitid_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_STATUS  = 8'h04;
  localparam logic [7:0] ADR_MB_INFO = 8'h08;
  localparam logic [7:0] ADR_MB_POS  = 8'h0C;
  localparam logic [7:0] ADR_MV0     = 8'h10;
  localparam logic [7:0] ADR_MV3     = 8'h1C;
  // Control and status fields
  localparam int         CTRL_EN_BIT   = 0;
  localparam logic       CTRL_EN_RST   = 1'b1;
  localparam int         ST_BUSY_BIT   = 0;
  localparam int         ST_KIND_BIT   = 1;
  localparam int         ST_FRAME_BIT  = 2;
  localparam int         ST_MV_BIT     = 3;
  localparam int         ST_CNT_LSB    = 16;
  // First inline dword fields
  localparam int         MT_MSB        = 25;
  localparam int         MT_LSB        = 24;
  localparam int         DCT_BIT       = 21;
  localparam int         BWD_BIT       = 18;
  localparam int         FWD_BIT       = 17;
  localparam int         INTRA_BIT     = 16;
  localparam int         CBP_MSB       = 11;
  localparam int         CBP_LSB       = 6;
  localparam int         ROW_END_BIT   = 3;
  // Second inline dword fields
  localparam int         VPOS_MSB      = 15;
  localparam int         VPOS_LSB      = 8;
  localparam int         HPOS_MSB      = 7;
  localparam int         HPOS_LSB      = 0;
  // Motion vector dword fields, half-sample units
  localparam int         MV_V_MSB      = 31;
  localparam int         MV_V_LSB      = 16;
  localparam int         MV_H_MSB      = 15;
  localparam int         MV_H_LSB      = 0;
  localparam logic signed [15:0] MV_MIN = 16'shF000;
  localparam logic signed [15:0] MV_MAX = 16'sh0FFF;
  // Command dword positions
  localparam logic [3:0] HDR_LAST      = 4'h6;
  localparam logic [3:0] INL_DW0       = 4'h7;
  localparam logic [3:0] INL_DW1       = 4'h8;
  localparam logic [3:0] INL_MV_FIRST  = 4'h9;
  localparam logic [3:0] INL_LAST      = 4'hD;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  // Parser states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_HDR = 2'b01, ST_INL = 2'b10, ST_COEF = 2'b11
  } mitid_state_e;
  // Indirect payload kinds
  typedef enum logic [1:0] {
    PK_COEF = 2'b00, PK_OTHER1 = 2'b01, PK_OTHER2 = 2'b10, PK_OTHER3 = 2'b11
  } mitid_payload_e;
  // Decoded prediction kinds
  typedef enum logic [2:0] {
    MK_NONE = 3'b000, MK_FIELD = 3'b001, MK_FRAME = 3'b010,
    MK_16X8 = 3'b011, MK_DUAL = 3'b100, MK_RSVD = 3'b101
  } mitid_motion_e;
endpackage : mitid_pkg

// ---- verilog/mitid_motion_kind.sv ----
// Motion type field to prediction kind translation
`timescale 1ns/10ps
module mitid_motion_kind
  import mitid_pkg::*;
(
  // Raw field and picture kind
  input  wire logic [1:0]    code_i,
  input  wire logic          pic_frame_i,
  input  wire logic          intra_i,
  // Decoded kind
  output mitid_motion_e      kind_o
);
  // Intra blocks never predict, so the code is not looked at
  always_comb
  begin
    kind_o = MK_RSVD;
    if (intra_i)
    begin
      kind_o = MK_NONE;
    end
    else
    begin
      case (code_i)
        2'b01:   kind_o = MK_FIELD;
        2'b10:   kind_o = pic_frame_i ? MK_FRAME : MK_16X8;
        2'b11:   kind_o = MK_DUAL;
        default: kind_o = MK_RSVD;
      endcase
    end
  end
endmodule : mitid_motion_kind

// ---- verilog/mitid_mv_unpack.sv ----
// Splits one motion vector dword into its two components
`timescale 1ns/10ps
module mitid_mv_unpack
  import mitid_pkg::*;
(
  // Packed vector and use flag
  input  wire logic [31:0]   dword_i,
  input  wire logic          used_i,
  // Components, zero when unused
  output logic [15:0]        vert_o,
  output logic [15:0]        horz_o,
  output logic               range_bad_o
);
  logic signed [15:0] vert_raw;  // Vertical, s11.1
  logic signed [15:0] horz_raw;  // Horizontal, s11.1

  // Unused vectors are zeroed so nothing downstream can apply them
  always_comb
  begin
    vert_raw    = dword_i[MV_V_MSB:MV_V_LSB];
    horz_raw    = dword_i[MV_H_MSB:MV_H_LSB];
    vert_o      = used_i ? vert_raw : 16'h0000;
    horz_o      = used_i ? horz_raw : 16'h0000;
    range_bad_o = used_i && (vert_raw < MV_MIN || vert_raw > MV_MAX ||
                             horz_raw < MV_MIN || horz_raw > MV_MAX);
  end
endmodule : mitid_mv_unpack

// ---- verilog/mitid_decoder.sv ----
// Inline macroblock parameter decoder for inverse-transform commands
// How it works
// - Motion type picks field, frame/16x8, dual-prime
// - Bit 21 selects frame or field residual
// - Bit 18 enables backward motion vectors
// - Bit 17 enables forward motion vectors
// - Intra ignores block mask and all vectors
// - Block mask bits 11..6 are Y0..Y3,Cb,Cr
// - Bit 3 of dword zero ends row
// - Row position 15:8, column 7:0, dword one
// - Vectors are signed 16-bit half-sample offsets
// - Four vector dwords: F0 fwd, bwd, F1 fwd, bwd
// - Coefficient payload expected as indirect data; other kinds drained but flagged
// - One command carries exactly one macroblock
// - Seven inline dwords start at dword seven
`timescale 1ns/10ps
module mitid_decoder
  import mitid_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // Command dwords from the streamer
  input  wire logic              dw_valid_i,
  input  wire logic              dw_sop_i,
  input  wire logic [31:0]       dw_data_i,
  output logic                   dw_ready_o,
  // Indirect payload words
  input  wire logic              coef_valid_i,
  input  wire logic              coef_last_i,
  input  wire mitid_payload_e    coef_kind_i,
  output logic                   coef_ready_o,
  // Picture kind
  input  wire logic              pic_frame_i,
  // Decoded macroblock
  output logic                   mb_valid_o,
  output mitid_motion_e          motion_kind_format_o,
  output logic                   field_residual_code_o,
  output logic                   fwd_en_o,
  output logic                   bwd_en_o,
  output logic                   intra_o,
  output logic [5:0]             block_mask_o,
  output logic                   row_end_marker_o,
  output logic [7:0]             mb_row_position_o,
  output logic [7:0]             mb_column_position_o,
  output logic [3:0][15:0]       mv_vert_o,
  output logic [3:0][15:0]       mv_horz_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    mitid_state_e        st;         // Parser state
    logic [3:0]          idx;        // Index of next command dword
    logic [31:0]         dw0;        // Inline dword zero
    logic [31:0]         dw1;        // Inline dword one
    logic [3:0][31:0]    mv;         // Raw vector dwords
    logic                en;         // Software enable
    logic                kind_err;   // Foreign payload seen
    logic                frame_err;  // Broken command framing
    logic                mv_err;     // Vector out of range
    logic [15:0]         mb_cnt;     // Finished macroblocks
    logic                mb_valid;   // Result pulse
    mitid_motion_e       kind;       // Prediction kind
    logic                field_dct;  // Residual arrangement
    logic                fwd;        // Forward vectors in use
    logic                bwd;        // Backward vectors in use
    logic                intra;      // Intra macroblock
    logic                row_end;    // Last of row
    logic [5:0]          mask;       // Blocks present
    logic [7:0]          row;        // Row position
    logic [7:0]          col;        // Column position
    logic [3:0][15:0]    mv_v;       // Vertical components
    logic [3:0][15:0]    mv_h;       // Horizontal components
    logic                ack;        // Bus answer
    logic [31:0]         rdat;       // Bus read data
  } mitid_core_s;

  mitid_core_s   q_reg;             // Registered state
  mitid_core_s   q_next;            // Next state
  mitid_motion_e kind_dec;          // Decoded kind of stored dword
  logic [3:0][15:0] v_dec;          // Unpacked vertical parts
  logic [3:0][15:0] h_dec;          // Unpacked horizontal parts
  logic [3:0]    mv_bad;            // Range faults per vector
  logic [3:0]    mv_used;           // Vector applied
  logic          dec_intra;         // Intra flag of stored dword
  logic          dec_fwd;           // Forward enable after intra gate
  logic          dec_bwd;           // Backward enable after intra gate
  logic          dw_take;           // Command dword accepted
  logic          coef_take;         // Payload word accepted

  ////////////////////////////////////////////////////////////////////////////
  // Field decoding of the stored inline dwords
  assign dec_intra = q_reg.dw0[INTRA_BIT];
  assign dec_fwd   = q_reg.dw0[FWD_BIT] && !dec_intra;
  assign dec_bwd   = q_reg.dw0[BWD_BIT] && !dec_intra;

  mitid_motion_kind u_kind (
    .code_i      (q_reg.dw0[MT_MSB:MT_LSB]),
    .pic_frame_i (pic_frame_i),
    .intra_i     (dec_intra),
    .kind_o      (kind_dec)
  );

  // Even slots are forward, odd slots backward
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_mv
      assign mv_used[gi] = (gi % 2 == 1) ? dec_bwd : dec_fwd;
      mitid_mv_unpack u_mv (
        .dword_i     (q_reg.mv[gi]),
        .used_i      (mv_used[gi]),
        .vert_o      (v_dec[gi]),
        .horz_o      (h_dec[gi]),
        .range_bad_o (mv_bad[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes
  // Commands stall while the payload of the last one drains, which keeps
  // one macroblock per command without any buffer
  assign dw_ready_o   = q_reg.en && (q_reg.st != ST_COEF);
  assign coef_ready_o = (q_reg.st == ST_COEF);
  assign dw_take      = dw_valid_i && dw_ready_o;
  assign coef_take    = coef_valid_i && coef_ready_o;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic set_kind;
    logic set_frame;
    logic set_mv;
    logic bus_req;
    set_kind   = 1'b0;
    set_frame  = 1'b0;
    set_mv     = 1'b0;
    bus_req    = wb_cyc_i && wb_stb_i && !q_reg.ack;
    q_next     = q_reg;
    q_next.mb_valid = 1'b0;
    // Command parser
    if (dw_take)
    begin
      if (dw_sop_i)
      begin
        // A start inside a command means the old one was cut short
        set_frame  = (q_reg.st != ST_IDLE);
        q_next.st  = ST_HDR;
        q_next.idx = 4'h1;
      end
      else if (q_reg.st == ST_IDLE)
      begin
        set_frame = 1'b1;
      end
      else
      begin
        q_next.idx = q_reg.idx + 4'h1;
        if (q_reg.idx == HDR_LAST)
        begin
          q_next.st = ST_INL;
        end
        if (q_reg.idx == INL_DW0)
        begin
          q_next.dw0 = dw_data_i;
        end
        else if (q_reg.idx == INL_DW1)
        begin
          q_next.dw1 = dw_data_i;
        end
        else if (q_reg.idx >= INL_MV_FIRST && q_reg.idx < INL_LAST)
        begin
          q_next.mv[2'(q_reg.idx - INL_MV_FIRST)] = dw_data_i;
        end
        else if (q_reg.idx == INL_LAST)
        begin
          // Seventh dword carries nothing used here
          q_next.st        = ST_COEF;
          q_next.mb_valid  = 1'b1;
          q_next.kind      = kind_dec;
          q_next.field_dct = q_reg.dw0[DCT_BIT];
          q_next.fwd       = dec_fwd;
          q_next.bwd       = dec_bwd;
          q_next.intra     = dec_intra;
          q_next.mask      = dec_intra ? 6'h00
                             : q_reg.dw0[CBP_MSB:CBP_LSB];
          q_next.row_end   = q_reg.dw0[ROW_END_BIT];
          q_next.row       = q_reg.dw1[VPOS_MSB:VPOS_LSB];
          q_next.col       = q_reg.dw1[HPOS_MSB:HPOS_LSB];
          q_next.mv_v      = v_dec;
          q_next.mv_h      = h_dec;
          set_mv           = |mv_bad;
        end
      end
    end
    // Indirect payload, drained until its last word
    if (coef_take)
    begin
      set_kind = (coef_kind_i != PK_COEF);
      if (coef_last_i)
      begin
        q_next.st     = ST_IDLE;
        q_next.mb_cnt = q_reg.mb_cnt + 16'h0001;
      end
    end
    // Bus answer one cycle after the strobe, dropped the cycle after
    q_next.ack = bus_req;
    q_next.rdat = 32'h0000_0000;
    if (bus_req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == ADR_CTRL)
      begin
        q_next.en = wb_dat_i[CTRL_EN_BIT];
      end
      else if (wb_adr_i == ADR_STATUS)
      begin
        // Write one to clear; a same-cycle event is applied after
        if (wb_dat_i[ST_KIND_BIT])  q_next.kind_err  = 1'b0;
        if (wb_dat_i[ST_FRAME_BIT]) q_next.frame_err = 1'b0;
        if (wb_dat_i[ST_MV_BIT])    q_next.mv_err    = 1'b0;
      end
    end
    if (set_kind)  q_next.kind_err  = 1'b1;
    if (set_frame) q_next.frame_err = 1'b1;
    if (set_mv)    q_next.mv_err    = 1'b1;
    // Read decode, unmapped offsets read as zero
    if (bus_req && !wb_we_i)
    begin
      if (wb_adr_i == ADR_CTRL)
      begin
        q_next.rdat[CTRL_EN_BIT] = q_reg.en;
      end
      else if (wb_adr_i == ADR_STATUS)
      begin
        q_next.rdat[ST_BUSY_BIT]  = (q_reg.st != ST_IDLE);
        q_next.rdat[ST_KIND_BIT]  = q_reg.kind_err;
        q_next.rdat[ST_FRAME_BIT] = q_reg.frame_err;
        q_next.rdat[ST_MV_BIT]    = q_reg.mv_err;
        q_next.rdat[31:ST_CNT_LSB] = q_reg.mb_cnt;
      end
      else if (wb_adr_i == ADR_MB_INFO)
      begin
        q_next.rdat[13:0] = {q_reg.mask, q_reg.row_end, q_reg.intra,
                             q_reg.bwd, q_reg.fwd, q_reg.field_dct,
                             q_reg.kind};
      end
      else if (wb_adr_i == ADR_MB_POS)
      begin
        q_next.rdat[15:0] = {q_reg.row, q_reg.col};
      end
      else if (wb_adr_i >= ADR_MV0 && wb_adr_i <= ADR_MV3
               && wb_adr_i[1:0] == 2'b00)
      begin
        q_next.rdat = {q_reg.mv_v[wb_adr_i[3:2]], q_reg.mv_h[wb_adr_i[3:2]]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_reg        <= '0;
      q_reg.st     <= ST_IDLE;
      q_reg.kind   <= MK_NONE;
      q_reg.en     <= CTRL_EN_RST;
      q_reg.mb_cnt <= CNT_RST;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign wb_ack_o              = q_reg.ack;
  assign wb_dat_o              = q_reg.rdat;
  assign mb_valid_o            = q_reg.mb_valid;
  assign motion_kind_format_o  = q_reg.kind;
  assign field_residual_code_o = q_reg.field_dct;
  assign fwd_en_o              = q_reg.fwd;
  assign bwd_en_o              = q_reg.bwd;
  assign intra_o               = q_reg.intra;
  assign block_mask_o          = q_reg.mask;
  assign row_end_marker_o      = q_reg.row_end;
  assign mb_row_position_o     = q_reg.row;
  assign mb_column_position_o  = q_reg.col;
  assign mv_vert_o             = q_reg.mv_v;
  assign mv_horz_o             = q_reg.mv_h;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_DUAL_PRIME: assert property (
    mb_valid_o && !intra_o && q_reg.dw0[MT_MSB:MT_LSB] == 2'b11
    |-> motion_kind_format_o == MK_DUAL)
    else $error("dual-prime code not decoded");
  AST_RESIDUAL: assert property (
    mb_valid_o |-> field_residual_code_o == q_reg.dw0[DCT_BIT])
    else $error("residual arrangement mismatch");
  AST_BWD_OFF: assert property (
    mb_valid_o && !bwd_en_o |-> mv_vert_o[1] == 16'h0000
    && mv_horz_o[3] == 16'h0000)
    else $error("backward vector applied while disabled");
  AST_FWD_EN: assert property (
    mb_valid_o |-> fwd_en_o == (q_reg.dw0[FWD_BIT] && !q_reg.dw0[INTRA_BIT]))
    else $error("forward enable mismatch");
  AST_INTRA: assert property (
    mb_valid_o && intra_o |-> !fwd_en_o && !bwd_en_o
    && block_mask_o == 6'h00 && motion_kind_format_o == MK_NONE)
    else $error("intra macroblock still predicts");
  AST_MASK: assert property (
    mb_valid_o && !intra_o |-> block_mask_o[5] == q_reg.dw0[CBP_MSB]
    && block_mask_o[0] == q_reg.dw0[CBP_LSB])
    else $error("block mask order wrong");
  AST_POSITION: assert property (
    mb_valid_o |-> mb_row_position_o == q_reg.dw1[VPOS_MSB:VPOS_LSB]
    && row_end_marker_o == q_reg.dw0[ROW_END_BIT])
    else $error("position or row end mismatch");
  AST_KIND_ERR: assert property (
    coef_take && coef_kind_i != PK_COEF |=> q_reg.kind_err)
    else $error("foreign payload not flagged");
  AST_ONE_MB: assert property (
    mb_valid_o |-> q_reg.st == ST_COEF && !dw_ready_o ##1 !mb_valid_o)
    else $error("second macroblock before payload end");
  AST_INLINE_END: assert property (
    $rose(mb_valid_o) |-> $past(q_reg.idx) == INL_LAST
    && $past(q_reg.st) == ST_INL)
    else $error("inline block length wrong");
  AST_BUS_ACK: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");

  COV_MB: cover property (mb_valid_o && !intra_o && fwd_en_o && bwd_en_o);
  COV_INTRA: cover property (mb_valid_o && intra_o);
  COV_DONE: cover property (coef_take && coef_last_i);
  COV_FRAME_ERR: cover property (dw_take && dw_sop_i && q_reg.st == ST_INL);
endmodule : mitid_decoder

// ---- dv/mitid_streamer_model.sv ----
// Command streamer model feeding one macroblock command and its payload
`timescale 1ns/10ps
module mitid_streamer_model
  import mitid_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Bench control
  input  wire logic              start_i,
  input  wire logic              gap_i,
  input  wire logic [13:0][31:0] cmd_i,
  input  wire mitid_payload_e    kind_i,
  output logic                   busy_o,
  // Command dword port
  output logic                   dw_valid_o,
  output logic                   dw_sop_o,
  output logic [31:0]            dw_data_o,
  input  wire logic              dw_ready_i,
  // Payload port
  output logic                   coef_valid_o,
  output logic                   coef_last_o,
  output mitid_payload_e         coef_kind_o,
  input  wire logic              coef_ready_i
);
  logic [3:0] idx_reg;  // Index of the dword on offer

  // One payload word, so every word is also the last
  assign coef_last_o = coef_valid_o;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: holds each dword until taken; gap_i adds one idle cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o       <= 1'b0;
      idx_reg      <= 4'h0;
      dw_valid_o   <= 1'b0;
      dw_sop_o     <= 1'b0;
      dw_data_o    <= 32'h0000_0000;
      coef_valid_o <= 1'b0;
      coef_kind_o  <= PK_COEF;
    end
    else
    begin
      if (dw_valid_o && dw_ready_i)
      begin
        // Released data shows the inverse, never a stale copy
        idx_reg      <= idx_reg + 4'h1;
        dw_sop_o     <= 1'b0;
        dw_valid_o   <= !gap_i && idx_reg != 4'hD;
        dw_data_o    <= (!gap_i && idx_reg != 4'hD) ? cmd_i[idx_reg + 4'h1] : ~dw_data_o;
        coef_valid_o <= idx_reg == 4'hD;
        coef_kind_o  <= kind_i;
      end
      else if (busy_o && !dw_valid_o && idx_reg <= 4'hD)
      begin
        dw_valid_o <= 1'b1;
        dw_sop_o   <= idx_reg == 4'h0;
        dw_data_o  <= cmd_i[idx_reg];
      end
      if (coef_valid_o && coef_ready_i)
      begin
        coef_valid_o <= 1'b0;
        busy_o       <= 1'b0;
      end
      if (start_i)
      begin
        busy_o  <= 1'b1;
        idx_reg <= 4'h0;
      end
    end
  end
endmodule : mitid_streamer_model

// ---- dv/tb_mpeg2_it_inline_macroblock_decoder.sv ----
// Self-checking bench for the inline macroblock parameter decoder
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb_mpeg2_it_inline_macroblock_decoder;
  import mitid_pkg::*;
  // Row of the table: inline dwords, picture kind, expected prediction kind
  typedef struct {logic [31:0] flags; logic [31:0] pos; logic pic; mitid_motion_e kind;} mitid_row_s;
  localparam logic [3:0][31:0] MVS = {32'hFFFE_0002, 32'h0001_FFFF, 32'h0FFF_F000, 32'hF000_0FFF};
  // Producer keeps cbp-free rows at frame residual and vectors in range
  mitid_row_s rows [7] = '{
    '{32'h0126_0808, 32'h0000_0C22, 1'b0, MK_FIELD}, '{32'h06D2_F077, 32'hFFFF_0001, 1'b1, MK_FRAME},
    '{32'h0224_0780, 32'h0000_FF00, 1'b0, MK_16X8}, '{32'h0302_0448, 32'h0000_00FF, 1'b0, MK_DUAL},
    '{32'h0306_0000, 32'h0000_7F80, 1'b1, MK_DUAL}, '{32'h0001_0FC0, 32'h0000_0000, 1'b1, MK_NONE},
    '{32'h0002_0080, 32'h0000_1234, 1'b1, MK_RSVD}};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pic_frame_i;  // Bench-driven pins, plus wb_ack_o from the decoder
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic dw_valid_i, dw_sop_i, dw_ready_o, coef_valid_i, coef_last_i, coef_ready_o;
  logic [31:0] dw_data_i;
  mitid_payload_e coef_kind_i, kind;
  logic mb_valid_o, field_residual_code_o, fwd_en_o, bwd_en_o, intra_o, row_end_marker_o;
  mitid_motion_e motion_kind_format_o;
  logic [5:0] block_mask_o;
  logic [7:0] mb_row_position_o, mb_column_position_o;
  logic [3:0][15:0] mv_vert_o, mv_horz_o;
  logic start, gap, busy;  // Model control
  logic [13:0][31:0] cmd;
  int fail_count = 0;
  int cmp_count = 0;
  wire [1:0] lvl = {busy, mb_valid_o};  // Levels watched by wait_lvl: 0 result, 1 model busy

  mitid_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dw_valid_i(dw_valid_i), .dw_sop_i(dw_sop_i),
    .dw_data_i(dw_data_i), .dw_ready_o(dw_ready_o), .coef_valid_i(coef_valid_i),
    .coef_last_i(coef_last_i), .coef_kind_i(coef_kind_i), .coef_ready_o(coef_ready_o),
    .pic_frame_i(pic_frame_i), .mb_valid_o(mb_valid_o),
    .motion_kind_format_o(motion_kind_format_o), .field_residual_code_o(field_residual_code_o),
    .fwd_en_o(fwd_en_o), .bwd_en_o(bwd_en_o), .intra_o(intra_o), .block_mask_o(block_mask_o),
    .row_end_marker_o(row_end_marker_o), .mb_row_position_o(mb_row_position_o),
    .mb_column_position_o(mb_column_position_o), .mv_vert_o(mv_vert_o), .mv_horz_o(mv_horz_o));
  mitid_streamer_model model (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .gap_i(gap),
    .cmd_i(cmd), .kind_i(kind), .busy_o(busy), .dw_valid_o(dw_valid_i), .dw_sop_o(dw_sop_i),
    .dw_data_o(dw_data_i), .dw_ready_i(dw_ready_o), .coef_valid_o(coef_valid_i),
    .coef_last_o(coef_last_i), .coef_kind_o(coef_kind_i), .coef_ready_i(coef_ready_o));

  ////////////////////////////////////////////////////////////////////////////
  // Clock: 20 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Bounded wait at falling edges for a settled level; a hang counts as a mismatch
  task automatic wait_lvl(input int sel, input logic v);
    int n;
    for (n = 0; n < 80 && lvl[sel] !== v; n++)
      @(negedge clk_i);
    if (lvl[sel] !== v)
    begin
      fail_count++;
      $display("Error at %0t: wait ran out", $time);
      test_done();
    end
  endtask : wait_lvl

  // Classic single Wishbone cycle; held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      $display("Error at %0t: bus answer missing", $time);
      test_done();
    end
  endtask : wb_xfer

  // Sends one command from a row and checks the decoded macroblock
  task automatic run_mb(input int r, input mitid_payload_e pk);
    logic [31:0] f;
    logic i, u;
    f = rows[r].flags;
    i = f[16];
    @(posedge clk_i);
    cmd[7] <= f;
    cmd[8] <= rows[r].pos;
    pic_frame_i <= rows[r].pic;
    kind <= pk;
    gap <= r[0];
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    wait_lvl(0, 1'b1);
    `CHK(motion_kind_format_o, rows[r].kind)
    `CHK(field_residual_code_o, f[21])
    `CHK(bwd_en_o, f[18] & ~i)
    `CHK(fwd_en_o, f[17] & ~i)
    `CHK(intra_o, i)
    `CHK(block_mask_o, i ? 6'h00 : f[11:6])
    `CHK(row_end_marker_o, f[3])
    `CHK({mb_row_position_o, mb_column_position_o}, rows[r].pos[15:0])
    for (int k = 0; k < 4; k++)
    begin
      u = (k[0] ? f[18] : f[17]) & ~i;
      `CHK(mv_vert_o[k], u ? MVS[k][31:16] : 16'h0000)
      `CHK(mv_horz_o[k], u ? MVS[k][15:0] : 16'h0000)
    end
    wait_lvl(1, 1'b0);
  endtask : run_mb

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: table rows, then registers, foreign payload and reset
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pic_frame_i, start, gap} = 7'b100_0000;
    {wb_adr_i, wb_dat_i, q} = '0;
    kind = PK_COEF;
    for (int j = 0; j < 14; j++)
      cmd[j] = 32'(j);
    cmd[12:9] = MVS;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 7; r++)
      run_mb(r, PK_COEF);
    wb_xfer(1'b0, ADR_MB_INFO, 32'h0000_0000);
    `CHK(q, 32'h0000_0215)
    wb_xfer(1'b0, ADR_MB_POS, 32'h0000_0000);
    `CHK(q, 32'h0000_1234)
    wb_xfer(1'b0, ADR_MV0, 32'h0000_0000);
    `CHK(q, 32'hF000_0FFF)
    wb_xfer(1'b0, ADR_MV3, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    wb_xfer(1'b1, ADR_CTRL, 32'h0000_0000);
    `CHK(dw_ready_o, 1'b0)
    wb_xfer(1'b1, ADR_CTRL, 32'h0000_0001);
    wb_xfer(1'b0, ADR_CTRL, 32'h0000_0000);
    `CHK(q, 32'h0000_0001)
    wb_xfer(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK(q, 32'h0007_0000)
    wb_xfer(1'b0, 8'h40, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    run_mb(1, PK_OTHER2);
    wb_xfer(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK(q[1], 1'b1)
    wb_xfer(1'b1, ADR_STATUS, 32'h0000_0002);
    wb_xfer(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK(q, 32'h0008_0000)
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK({q, dw_ready_o, coef_ready_o}, 34'h0_0000_0002)
    run_mb(0, PK_COEF);
    test_done();
  end
endmodule : tb_mpeg2_it_inline_macroblock_decoder
